// ==== e3_rx_latch_pkg.sv ====
// Purpose: shared constants and carriers for the e3 receive status latch block
// Assumes: byte offsets on a 12-bit register address, 16-bit register data
// Notes: offsets are byte addresses as printed; registers are 16 bits wide
package e3_rx_latch_pkg;

  // register offsets
  localparam logic [11:0] CTRL_OFFSET = 12'h120;
  localparam logic [11:0] STATUS1_OFFSET = 12'h124;
  localparam logic [11:0] STATUS2_OFFSET = 12'h126;
  localparam logic [11:0] LATCH1_OFFSET = 12'h128;
  localparam logic [11:0] LATCH2_OFFSET = 12'h12a;
  localparam logic [11:0] IRQ_EN1_OFFSET = 12'h12c;
  localparam logic [11:0] IRQ_EN2_OFFSET = 12'h12e;
  localparam logic [11:0] COUNTER_OFFSET = 12'h134;

  // field positions
  localparam int CTRL_ALARM_COUNT_BIT = 10;
  localparam int CTRL_SELECT_LSB = 8;
  localparam int ALIGN_CHANGE_BIT = 5;
  localparam int FRAMING_ERROR_BIT = 8;
  localparam int COUNT_NONZERO_BIT = 0;

  // implemented bits of each register
  localparam logic [15:0] CTRL_MASK = 16'h0700;
  localparam logic [15:0] LATCH1_MASK = 16'h01ff;
  localparam logic [15:0] LATCH2_MASK = 16'h0101;

  // reset values
  localparam logic [15:0] REG_RESET = 16'h0000;

  // framing count select encodings
  localparam logic [1:0] SEL_OOF = 2'h0;
  localparam logic [1:0] SEL_FAS_BITS = 2'h1;
  localparam logic [1:0] SEL_FAS_WORDS = 2'h2;

  // register port request
  typedef struct packed {
    logic [11:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } reg_req_type;

  // live receive conditions, in status-register bit order 8..0 less bit 5
  typedef struct packed {
    logic unframed_all_ones;
    logic received_a_bit;
    logic received_n_bit;
    logic lof;
    logic rdi;
    logic ais;
    logic oof;
    logic los;
  } live_status_type;

  // per-frame framing events from the frame processor
  typedef struct packed {
    logic [3:0] fas_bit_errors;
    logic fas_word_error;
    logic alignment_change;
  } frame_event_type;

endpackage : e3_rx_latch_pkg

// ==== e3_rx_status_latch_irq.sv ====
// Purpose: receive alarm change latches, interrupt gating and framing error count
// Assumes: all framer inputs are produced on i_clock; i_rst_n is synchronous
// Notes: registers are reached over a plain strobe port, read data one cycle later
// Function
// - count-nonzero status mirrors count one or more
// - unframed all-ones toggle sets latch bit 8
// - A and N bit changes set bits 7, 6
// - new differing frame alignment sets bit 5
// - LOF and RDI changes set bits 4, 3
// - AIS, OOF, LOS changes set bits 2..0
// - each framing error sets second latch bit 8
// - count-nonzero rising edge sets second latch bit 0
// - interrupt needs latch, enable and port gate
// - first enable bits map to same latch bits
// - second enable bits 8, 0 gate their latches
// - sixteen-bit framing error count readable by software
// - count register changes only on monitor update
// - count select picks OOF, FAS bits, FAS words
// - alarm-count control clear suppresses FAS counting during OOF/AIS
//
// Design decision made here: strobed register access.
`timescale 1ns/1ps

module e3_rx_status_latch_irq #(
  parameter int CW = 16
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // register port
  input wire e3_rx_latch_pkg::reg_req_type i_reg,
  output logic [15:0] o_rdata,
  // framer side
  input wire e3_rx_latch_pkg::live_status_type i_live,
  input wire e3_rx_latch_pkg::frame_event_type i_frame,
  input wire logic i_perf_monitor_update,
  // global port gate from the chip-level enable register
  input wire logic i_port_status_irq_gate,
  // outputs
  output logic o_irq,
  output logic o_framing_count_nonzero
);

  // write-one-to-clear with set priority
  // a clear never loses an event that lands in the same cycle
  function automatic logic [15:0] w1c_next(
    input logic [15:0] q,
    input logic [15:0] set,
    input logic clear,
    input logic [15:0] wdata
  );
    logic [15:0] clr;
    clr = clear ? wdata : 16'h0000;
    w1c_next = (q & ~clr) | set;
  endfunction : w1c_next

  // add without wrapping
  // holding at all ones keeps an overflowed interval from reading small
  function automatic logic [CW-1:0] sat_add(
    input logic [CW-1:0] a,
    input logic [3:0] b
  );
    logic [CW:0] s;
    s = {1'b0, a} + (CW+1)'(b);
    sat_add = s[CW] ? {CW{1'b1}} : s[CW-1:0];
  endfunction : sat_add

  // one address compare shared by every register strobe
  function automatic logic reg_hit(
    input logic strobe,
    input logic [11:0] addr,
    input logic [11:0] offset
  );
    reg_hit = strobe && (addr == offset);
  endfunction : reg_hit

  // plain read/write register update; unimplemented bits stay zero
  function automatic logic [15:0] rw_next(
    input logic [15:0] q,
    input logic hit,
    input logic [15:0] wdata,
    input logic [15:0] mask
  );
    rw_next = hit ? (wdata & mask) : q;
  endfunction : rw_next

  // eight live conditions in register order; bit 5 has no live source
  function automatic logic [15:0] live_layout(
    input logic [7:0] v
  );
    logic [15:0] w;
    w = 16'h0000;
    w[8:6] = v[7:5];
    w[4:0] = v[4:0];
    live_layout = w;
  endfunction : live_layout

  // register strobes
  logic wr_ctrl;
  logic wr_latch1;
  logic wr_latch2;
  logic wr_en1;
  logic wr_en2;

  assign wr_ctrl = reg_hit(i_reg.wr, i_reg.addr, e3_rx_latch_pkg::CTRL_OFFSET);
  assign wr_latch1 = reg_hit(i_reg.wr, i_reg.addr, e3_rx_latch_pkg::LATCH1_OFFSET);
  assign wr_latch2 = reg_hit(i_reg.wr, i_reg.addr, e3_rx_latch_pkg::LATCH2_OFFSET);
  assign wr_en1 = reg_hit(i_reg.wr, i_reg.addr, e3_rx_latch_pkg::IRQ_EN1_OFFSET);
  assign wr_en2 = reg_hit(i_reg.wr, i_reg.addr, e3_rx_latch_pkg::IRQ_EN2_OFFSET);

  // control register: count select and count-during-alarm
  // only bits 10:8 are kept here; the other control fields belong to other blocks
  logic [15:0] ctrl_q;
  logic [1:0] framing_count_select;
  logic count_during_alarm;

  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
      ctrl_q <= e3_rx_latch_pkg::REG_RESET;
    else
      ctrl_q <= rw_next(ctrl_q, wr_ctrl, i_reg.wdata, e3_rx_latch_pkg::CTRL_MASK);
  end

  assign framing_count_select = ctrl_q[e3_rx_latch_pkg::CTRL_SELECT_LSB +: 2];
  assign count_during_alarm = ctrl_q[e3_rx_latch_pkg::CTRL_ALARM_COUNT_BIT];

  // interrupt enable registers
  logic [15:0] irq_en1_q;
  logic [15:0] irq_en2_q;

  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
      irq_en1_q <= e3_rx_latch_pkg::REG_RESET;
    else
      irq_en1_q <= rw_next(irq_en1_q, wr_en1, i_reg.wdata, e3_rx_latch_pkg::LATCH1_MASK);
  end

  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
      irq_en2_q <= e3_rx_latch_pkg::REG_RESET;
    else
      irq_en2_q <= rw_next(irq_en2_q, wr_en2, i_reg.wdata, e3_rx_latch_pkg::LATCH2_MASK);
  end

  // live status history; the first cycle after reset only primes it,
  // so a condition already present at reset is not taken for a change
  e3_rx_latch_pkg::live_status_type live_prev_q;
  logic primed_q;

  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
      live_prev_q <= '0;
    else
      live_prev_q <= i_live;
  end

  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
      primed_q <= 1'b0;
    else
      primed_q <= 1'b1;
  end

  logic [7:0] live_change;
  logic [15:0] latch1_set;

  assign live_change = primed_q ? (i_live ^ live_prev_q) : 8'h00;

  always_comb
  begin
    latch1_set = live_layout(live_change);
    latch1_set[e3_rx_latch_pkg::ALIGN_CHANGE_BIT] = i_frame.alignment_change;
  end

  // framing event selection
  logic oof_rise;
  logic alarm_block;
  logic [3:0] frame_incr;
  logic framing_error_seen;

  assign oof_rise = primed_q && i_live.oof && !live_prev_q.oof;
  // oof occurrences are counted whatever the alarm-count control says
  assign alarm_block = !count_during_alarm && (i_live.oof || i_live.ais);
  assign framing_error_seen = i_frame.fas_word_error || (i_frame.fas_bit_errors != 4'h0);

  always_comb
  begin
    frame_incr = 4'h0;
    // the reserved select counts nothing rather than guessing a meaning
    case (framing_count_select)
      e3_rx_latch_pkg::SEL_OOF:
        frame_incr = {3'h0, oof_rise};
      e3_rx_latch_pkg::SEL_FAS_BITS:
        frame_incr = alarm_block ? 4'h0 : i_frame.fas_bit_errors;
      e3_rx_latch_pkg::SEL_FAS_WORDS:
        frame_incr = {3'h0, i_frame.fas_word_error && !alarm_block};
      default:
        frame_incr = 4'h0;
    endcase
  end

  // accumulator and presented count
  logic [CW-1:0] accum_q;
  logic [CW-1:0] counter_q;
  logic [CW-1:0] counter_d;
  logic nonzero_q;

  // an event in the update cycle opens the new interval instead of being lost
  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
      accum_q <= '0;
    else if (i_perf_monitor_update)
      accum_q <= sat_add('0, frame_incr);
    else
      accum_q <= sat_add(accum_q, frame_incr);
  end

  // software sees a whole interval, never a count in progress
  always_comb
  begin
    counter_d = counter_q;
    if (i_perf_monitor_update)
      counter_d = accum_q;
  end

  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
      counter_q <= '0;
    else
      counter_q <= counter_d;
  end

  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
      nonzero_q <= 1'b0;
    else
      nonzero_q <= (counter_d != '0);
  end

  assign o_framing_count_nonzero = nonzero_q;

  // second latch set terms
  // count-nonzero latches on the update edge that first makes the count nonzero
  logic [15:0] latch2_set;

  always_comb
  begin
    latch2_set = 16'h0000;
    latch2_set[e3_rx_latch_pkg::FRAMING_ERROR_BIT] = framing_error_seen;
    latch2_set[e3_rx_latch_pkg::COUNT_NONZERO_BIT] = !nonzero_q && (counter_d != '0);
  end

  // sticky change latches
  logic [15:0] latch1_q;
  logic [15:0] latch2_q;

  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
      latch1_q <= e3_rx_latch_pkg::REG_RESET;
    else
      latch1_q <= w1c_next(latch1_q, latch1_set, wr_latch1, i_reg.wdata);
  end

  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
      latch2_q <= e3_rx_latch_pkg::REG_RESET;
    else
      latch2_q <= w1c_next(latch2_q, latch2_set, wr_latch2, i_reg.wdata);
  end

  // interrupt request: level, follows the latches with no added delay
  logic [15:0] pending1;
  logic [15:0] pending2;

  assign pending1 = latch1_q & irq_en1_q;
  assign pending2 = latch2_q & irq_en2_q;
  assign o_irq = i_port_status_irq_gate && ((|pending1) || (|pending2));

  // live status words for read-back
  logic [15:0] status1_word;
  logic [15:0] status2_word;

  always_comb
  begin
    status1_word = live_layout(i_live);
    status2_word = 16'h0000;
    status2_word[e3_rx_latch_pkg::COUNT_NONZERO_BIT] = nonzero_q;
  end

  // read data, valid in the cycle after the strobe only; unmapped reads zero
  // a zero idle value lets several blocks share one or-ed read bus
  logic [15:0] rdata_q;
  logic [15:0] rdata_d;

  always_comb
  begin
    rdata_d = 16'h0000;
    if (i_reg.rd)
    begin
      case (i_reg.addr)
        e3_rx_latch_pkg::CTRL_OFFSET:
          rdata_d = ctrl_q;
        e3_rx_latch_pkg::STATUS1_OFFSET:
          rdata_d = status1_word;
        e3_rx_latch_pkg::STATUS2_OFFSET:
          rdata_d = status2_word;
        e3_rx_latch_pkg::LATCH1_OFFSET:
          rdata_d = latch1_q;
        e3_rx_latch_pkg::LATCH2_OFFSET:
          rdata_d = latch2_q;
        e3_rx_latch_pkg::IRQ_EN1_OFFSET:
          rdata_d = irq_en1_q;
        e3_rx_latch_pkg::IRQ_EN2_OFFSET:
          rdata_d = irq_en2_q;
        e3_rx_latch_pkg::COUNTER_OFFSET:
          rdata_d = 16'(counter_q);
        default:
          rdata_d = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
      rdata_q <= 16'h0000;
    else
      rdata_q <= rdata_d;
  end

  assign o_rdata = rdata_q;

endmodule : e3_rx_status_latch_irq

// ==== e3_rx_status_latch_irq_checker.sv ====
// Purpose: port-level checks for the receive status latch block
// Assumes: reads answer one cycle after the strobe
// Notes: latch check looks back three edges, so it waits out reset
`timescale 1ns/1ps
module e3_rx_status_latch_irq_checker #(
  parameter int CW = 16
) (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire e3_rx_latch_pkg::reg_req_type i_reg,
  input wire logic [15:0] o_rdata,
  input wire e3_rx_latch_pkg::live_status_type i_live,
  input wire e3_rx_latch_pkg::frame_event_type i_frame,
  input wire logic i_perf_monitor_update,
  input wire logic i_port_status_irq_gate,
  input wire logic o_irq,
  input wire logic o_framing_count_nonzero
);
  logic [7:0] l1_q;
  logic [7:0] l2_q;
  logic [7:0] l3_q;
  logic [2:0] rst_q;
  logic [7:0] d;
  logic [8:0] chg;
  always_ff @(posedge i_clock)
  begin
    l1_q <= i_live;
    l2_q <= l1_q;
    l3_q <= l2_q;
    rst_q <= {rst_q[1:0], i_rst_n};
  end
  // bit 5 has no live source, so the gap is zero
  assign d = l2_q ^ l3_q;
  assign chg = {d[7:5], 1'b0, d[4:0]};
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_rst_n);
  rdata_idle_a: assert property (!$past(i_reg.rd) |-> o_rdata == 16'h0000)
    else $error("read data not idle");
  reset_zero_a: assert property (!$past(i_rst_n) |-> o_rdata == 16'h0000 && !o_framing_count_nonzero && !o_irq)
    else $error("outputs not zero after reset");
  irq_gate_a: assert property (!i_port_status_irq_gate |-> !o_irq)
    else $error("irq without port gate");
  irq_hold_a: assert property ($past(i_rst_n) && $past(o_irq) && $past(i_port_status_irq_gate)
    && i_port_status_irq_gate && !$past(i_reg.wr) |-> o_irq)
    else $error("irq dropped without clear");
  nz_stable_a: assert property ($past(i_rst_n) && !$past(i_perf_monitor_update)
    |-> $stable(o_framing_count_nonzero))
    else $error("count flag moved without update");
  count_nz_a: assert property ($past(i_reg.rd) && $past(i_reg.addr) == 12'h134 && !$past(i_perf_monitor_update)
    |-> (o_rdata != 16'h0000) == o_framing_count_nonzero)
    else $error("count flag disagrees with count");
  status_nz_a: assert property ($past(i_reg.rd) && $past(i_reg.addr) == 12'h126 && !$past(i_perf_monitor_update)
    |-> o_rdata == {15'h0000, o_framing_count_nonzero})
    else $error("status flag wrong");
  live_latch_a: assert property (&rst_q && $past(i_reg.rd) && $past(i_reg.addr) == 12'h128
    |-> (o_rdata[8:0] & chg) == chg)
    else $error("live change not latched");
  latch2_rsv_a: assert property ($past(i_reg.rd) && $past(i_reg.addr) == 12'h12a
    |-> (o_rdata & 16'hfefe) == 16'h0000)
    else $error("reserved latch bits set");
endmodule : e3_rx_status_latch_irq_checker

bind e3_rx_status_latch_irq e3_rx_status_latch_irq_checker #(.CW(CW)) chk_i (.i_clock, .i_rst_n, .i_reg,
  .o_rdata, .i_live, .i_frame, .i_perf_monitor_update, .i_port_status_irq_gate, .o_irq, .o_framing_count_nonzero);

// ==== e3_rx_status_latch_irq_bench.sv ====
// Purpose: register-level bench for the receive status latch block
// Assumes: read data one cycle after the strobe
// Notes: saturation run is about 13k cycles
`timescale 1ns/1ps
module e3_rx_status_latch_irq_bench;
  logic i_clock = 1'b0;
  logic i_rst_n = 1'b0;
  e3_rx_latch_pkg::reg_req_type rq = '0;
  e3_rx_latch_pkg::live_status_type live = '0;
  e3_rx_latch_pkg::frame_event_type fr = '0;
  logic upd = 1'b0;
  logic gate = 1'b0;
  logic [15:0] rdata;
  logic irq;
  logic nz;
  logic [15:0] last = '0;
  int p;
  int n_mismatch = 0;
  int cmp_count = 0;
  e3_rx_status_latch_irq dut (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_reg(rq), .o_rdata(rdata),
    .i_live(live), .i_frame(fr), .i_perf_monitor_update(upd), .i_port_status_irq_gate(gate),
    .o_irq(irq), .o_framing_count_nonzero(nz));
  initial
  begin
    forever #20 i_clock = ~i_clock;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic stop_test();
    $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : stop_test
  task automatic wr(input logic [11:0] a, input logic [15:0] v);
    rq <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge i_clock);
    rq <= '0;
    @(posedge i_clock);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [15:0] exp);
    rq <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge i_clock);
    rq <= '0;
    #1;
    chk(rdata, exp);
    @(posedge i_clock);
  endtask : rd
  // pulse frame events and live toggles n times, then one monitor update
  task automatic cnt(input logic [15:0] c, input logic [5:0] f, input logic [7:0] lv, input int n,
    input logic [15:0] exp);
    wr(12'h120, c);
    repeat (n)
    begin
      fr <= f;
      live <= live ^ lv;
      @(posedge i_clock);
      fr <= '0;
      @(posedge i_clock);
    end
    rd(12'h134, last);
    upd <= 1'b1;
    @(posedge i_clock);
    upd <= 1'b0;
    @(posedge i_clock);
    rd(12'h134, exp);
    chk({15'h0000, nz}, {15'h0000, exp != 16'h0000});
    last = exp;
  endtask : cnt
  initial
  begin
    #2ms;
    n_mismatch++;
    stop_test();
  end
  initial
  begin
    repeat (6) @(posedge i_clock);
    i_rst_n <= 1'b1;
    repeat (2) @(posedge i_clock);
    rd(12'h12c, 16'h0000);
    rd(12'h134, 16'h0000);
    cnt(16'h0200, 6'h02, 8'h00, 3, 16'h0003);
    rd(12'h126, 16'h0001);
    rd(12'h12a, 16'h0101);
    wr(12'h12a, 16'hffff);
    cnt(16'h0100, 6'h28, 8'h00, 2, 16'h0014);
    rd(12'h12a, 16'h0100);
    cnt(16'h0300, 6'h2a, 8'h00, 2, 16'h0000);
    live.ais <= 1'b1;
    cnt(16'h0200, 6'h02, 8'h00, 2, 16'h0000);
    cnt(16'h0600, 6'h02, 8'h00, 2, 16'h0002);
    cnt(16'h0000, 6'h00, 8'h02, 4, 16'h0002);
    cnt(16'h0500, 6'h28, 8'h00, 6554, 16'hffff);
    cnt(16'h0300, 6'h00, 8'h00, 1, 16'h0000);
    live.ais <= 1'b0;
    wr(12'h12c, 16'hffff);
    rd(12'h12c, 16'h01ff);
    wr(12'h12e, 16'hffff);
    rd(12'h12e, 16'h0101);
    rd(12'h13e, 16'h0000);
    wr(12'h128, 16'hffff);
    wr(12'h12a, 16'hffff);
    gate <= 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      p = i < 5 ? i : i + 1;
      live <= live ^ (8'h01 << i);
      @(posedge i_clock);
      rd(12'h128, 16'h0001 << p);
      chk({15'h0000, irq}, 16'h0001);
      wr(12'h128, 16'h0001 << p);
      chk({15'h0000, irq}, 16'h0000);
    end
    live <= 8'h00;
    @(posedge i_clock);
    rd(12'h128, 16'h01df);
    wr(12'h128, 16'h0000);
    rd(12'h128, 16'h01df);
    fr <= 6'h01;
    @(posedge i_clock);
    fr <= '0;
    @(posedge i_clock);
    rd(12'h128, 16'h01ff);
    wr(12'h128, 16'hffff);
    wr(12'h12c, 16'h0000);
    live <= 8'h01;
    @(posedge i_clock);
    rd(12'h128, 16'h0001);
    chk({15'h0000, irq}, 16'h0000);
    wr(12'h12c, 16'h0001);
    chk({15'h0000, irq}, 16'h0001);
    wr(12'h12c, 16'h0000);
    chk({15'h0000, irq}, 16'h0000);
    fr <= 6'h02;
    @(posedge i_clock);
    fr <= '0;
    @(posedge i_clock);
    chk({15'h0000, irq}, 16'h0001);
    gate <= 1'b0;
    @(posedge i_clock);
    #1;
    chk({15'h0000, irq}, 16'h0000);
    stop_test();
  end
endmodule : e3_rx_status_latch_irq_bench
